/* src/relay_ctl_pkg.sv */
// Constants, types and timing figures for the two-channel learn and relay controller
package relay_ctl_pkg;

    localparam int REF_CLK_HZ = 100_000_000;
    localparam int MS_CYCLES = REF_CLK_HZ / 1000;

    // ----------------------------------------------------------------
    // Times in milliseconds, press counts and the flash bit
    // ----------------------------------------------------------------
    localparam logic [12:0] PHASE_TIMEOUT_MS = 13'd5000;
    localparam logic [12:0] CONFIRM_MS = 13'd500;
    localparam logic [12:0] READY_MS = 13'd2800;
    localparam logic [12:0] CFG_HOLD_MS = 13'd3000;
    localparam logic [12:0] TIME_PAUSE_MS = 13'd3000;
    localparam logic [12:0] DEBOUNCE_MS = 13'd20;
    localparam logic [12:0] FOLLOW_GAP_MS = 13'd150;
    localparam logic [12:0] TIME_STEP_MS = 13'd5000;
    localparam logic [7:0] DEFAULT_PRESSES = 8'h0c;
    localparam logic [7:0] MAX_PRESSES = 8'hf0;
    localparam int FLASH_BIT = 7;

    typedef enum logic [2:0] {
        ST_NORMAL = 3'b000,
        ST_LEARN1 = 3'b001,
        ST_LEARN2 = 3'b011,
        ST_ERASE = 3'b010,
        ST_CFG_SEL = 3'b110,
        ST_CFG_TIME = 3'b111
    } phase_t;

    typedef enum logic [1:0] {
        follow_frame_mode = 2'b00,
        toggle_output_mode = 2'b01,
        timed_hold_mode = 2'b10
    } out_mode_t;

    typedef struct packed {
        out_mode_t mode;
        logic [7:0] presses;
    } chan_cfg_t;

    typedef struct packed {
        logic green;
        logic red;
    } led_t;

    localparam chan_cfg_t CFG_RESET = '{mode: follow_frame_mode, presses: DEFAULT_PRESSES};

endpackage

/* src/relay_ctl.sv */
// Button-driven learn, erase and configuration control with two relay outputs
`timescale 1ns/100ps
module relay_ctl #(
    parameter int CLKS_PER_MS = relay_ctl_pkg::MS_CYCLES,
    parameter int CODE_W = 32,
    parameter int DEPTH = 500
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic btn_raw,
    input wire logic rx_valid,
    input wire logic [CODE_W-1:0] rx_code,
    input wire logic mem_fault,
    output relay_ctl_pkg::led_t led,
    output logic [1:0] relay,
    output logic rx_ready
);
    import relay_ctl_pkg::*;

    localparam int IDX_W = $clog2(DEPTH);

    // ----------------------------------------------------------------
    // Millisecond enable
    // ----------------------------------------------------------------
    logic [31:0] div_reg, div_next;
    logic ms_tick_reg, ms_tick_next;
    logic [12:0] ready_ms_reg, ready_ms_next;
    logic rx_ready_reg, rx_ready_next;
    logic [9:0] flash_reg, flash_next;

    always_comb begin
        ms_tick_next = (div_reg == 32'(CLKS_PER_MS - 1));
        div_next = ms_tick_next ? 32'h0 : div_reg + 32'h1;
        flash_next = ms_tick_reg ? flash_reg + 10'h1 : flash_reg;
        ready_ms_next = ready_ms_reg;
        rx_ready_next = rx_ready_reg;
        if (ms_tick_reg && !rx_ready_reg) begin
            ready_ms_next = ready_ms_reg + 13'h1;
            rx_ready_next = (ready_ms_reg == READY_MS - 13'h1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            div_reg <= 32'h0;
            ms_tick_reg <= 1'b0;
            ready_ms_reg <= 13'h0;
            rx_ready_reg <= 1'b0;
            flash_reg <= 10'h0;
        end else begin
            div_reg <= div_next;
            ms_tick_reg <= ms_tick_next;
            ready_ms_reg <= ready_ms_next;
            rx_ready_reg <= rx_ready_next;
            flash_reg <= flash_next;
        end
    end

    wire logic flash = flash_reg[FLASH_BIT];
    wire logic frame_ok = rx_valid && rx_ready_reg;

    // ----------------------------------------------------------------
    // Button debounce and hold timing
    // ----------------------------------------------------------------
    logic btn_db_reg, btn_db_next;
    logic [12:0] deb_reg, deb_next;
    logic [12:0] hold_reg, hold_next;
    logic press, hold_fire;

    always_comb begin
        deb_next = deb_reg;
        btn_db_next = btn_db_reg;
        if (btn_raw == btn_db_reg) begin
            deb_next = 13'h0;
        end else if (ms_tick_reg) begin
            deb_next = deb_reg + 13'h1;
            if (deb_reg == DEBOUNCE_MS - 13'h1) begin
                btn_db_next = btn_raw;
                deb_next = 13'h0;
            end
        end
        press = btn_db_next && !btn_db_reg;
        hold_fire = btn_db_reg && ms_tick_reg && hold_reg == CFG_HOLD_MS - 13'h1;
        hold_next = hold_reg;
        if (!btn_db_reg) begin
            hold_next = 13'h0;
        end else if (ms_tick_reg && hold_reg != CFG_HOLD_MS) begin
            hold_next = hold_reg + 13'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            btn_db_reg <= 1'b0;
            deb_reg <= 13'h0;
            hold_reg <= 13'h0;
        end else begin
            btn_db_reg <= btn_db_next;
            deb_reg <= deb_next;
            hold_reg <= hold_next;
        end
    end

    // ----------------------------------------------------------------
    // Code memory lookup
    // ----------------------------------------------------------------
    logic [CODE_W-1:0] code_mem [DEPTH];
    logic [1:0] chan_mem [DEPTH];
    logic hit, has_free;
    logic [IDX_W-1:0] hit_idx, free_idx;

    always_comb begin
        hit = 1'b0;
        has_free = 1'b0;
        hit_idx = '0;
        free_idx = '0;
        for (int i = DEPTH - 1; i >= 0; i--) begin
            if (chan_mem[i] != 2'b00 && code_mem[i] == rx_code) begin
                hit = 1'b1;
                hit_idx = IDX_W'(i);
            end
            if (chan_mem[i] == 2'b00) begin
                has_free = 1'b1;
                free_idx = IDX_W'(i);
            end
        end
    end

    // ----------------------------------------------------------------
    // Phase control
    // ----------------------------------------------------------------
    phase_t phase_reg, phase_next;
    logic [12:0] phase_ms_reg, phase_ms_next;
    logic [12:0] conf_ms_reg, conf_ms_next;
    logic done_reg, done_next;
    logic cfg_ch_reg, cfg_ch_next;
    out_mode_t sel_reg, sel_next;
    logic [7:0] cnt_reg, cnt_next;
    chan_cfg_t cfg_reg [2];
    chan_cfg_t cfg_next [2];
    logic wr_en, wipe_all;
    logic [IDX_W-1:0] wr_idx;
    logic [1:0] wr_bits;
    logic [1:0] chan_hit;

    always_comb begin
        phase_next = phase_reg;
        phase_ms_next = phase_ms_reg;
        conf_ms_next = conf_ms_reg;
        done_next = done_reg;
        cfg_ch_next = cfg_ch_reg;
        sel_next = sel_reg;
        cnt_next = cnt_reg;
        cfg_next = cfg_reg;
        wr_en = 1'b0;
        wipe_all = 1'b0;
        wr_idx = hit_idx;
        wr_bits = 2'b00;
        chan_hit = 2'b00;
        if (ms_tick_reg && conf_ms_reg != 13'h0) begin
            conf_ms_next = conf_ms_reg - 13'h1;
        end
        // Timeout only runs with the button up, so it starts at release
        if (btn_db_reg || press) begin
            phase_ms_next = 13'h0;
        end else if (ms_tick_reg) begin
            phase_ms_next = phase_ms_reg + 13'h1;
        end
        case (phase_reg)
            ST_NORMAL: begin
                if (frame_ok && hit) begin
                    chan_hit = chan_mem[hit_idx];
                end
                if (press) begin
                    phase_next = ST_LEARN1;
                    done_next = 1'b0;
                end
            end
            ST_LEARN1, ST_LEARN2: begin
                if (frame_ok && conf_ms_reg == 13'h0) begin
                    wr_bits = (phase_reg == ST_LEARN1) ? 2'b01 : 2'b10;
                    if (hit) begin
                        wr_en = 1'b1;
                        wr_bits = wr_bits | chan_mem[hit_idx];
                    end else if (has_free) begin
                        wr_en = 1'b1;
                        wr_idx = free_idx;
                    end
                end
                if (wr_en) begin
                    conf_ms_next = CONFIRM_MS;
                    phase_ms_next = 13'h0;
                    done_next = 1'b1;
                end
                if (hold_fire) begin
                    phase_next = ST_CFG_SEL;
                    cfg_ch_next = (phase_reg == ST_LEARN2);
                    sel_next = follow_frame_mode;
                    phase_ms_next = 13'h0;
                end else if (press) begin
                    // Once something was stored a press leaves, before that it steps on
                    phase_next = done_reg ? ST_NORMAL :
                        (phase_reg == ST_LEARN1 ? ST_LEARN2 : ST_ERASE);
                end else if (phase_ms_reg == PHASE_TIMEOUT_MS) begin
                    phase_next = ST_NORMAL;
                end
            end
            ST_ERASE: begin
                if (frame_ok && hit && conf_ms_reg == 13'h0) begin
                    wr_en = 1'b1;
                    conf_ms_next = CONFIRM_MS;
                    phase_ms_next = 13'h0;
                    done_next = 1'b1;
                end
                if (hold_fire) begin
                    wipe_all = 1'b1;
                    cfg_next[0] = CFG_RESET;
                    cfg_next[1] = CFG_RESET;
                    conf_ms_next = CONFIRM_MS;
                    phase_next = ST_NORMAL;
                end else if (press || phase_ms_reg == PHASE_TIMEOUT_MS) begin
                    phase_next = ST_NORMAL;
                end
            end
            ST_CFG_SEL: begin
                if (press) begin
                    phase_ms_next = 13'h0;
                    if (sel_reg == timed_hold_mode) begin
                        phase_next = ST_NORMAL;
                    end else begin
                        sel_next = out_mode_t'(sel_reg + 2'b01);
                    end
                end else if (phase_ms_reg == PHASE_TIMEOUT_MS) begin
                    phase_ms_next = 13'h0;
                    cnt_next = 8'h0;
                    if (sel_reg == timed_hold_mode) begin
                        phase_next = ST_CFG_TIME;
                    end else begin
                        cfg_next[cfg_ch_reg].mode = sel_reg;
                        phase_next = ST_NORMAL;
                    end
                end
            end
            ST_CFG_TIME: begin
                if (press) begin
                    conf_ms_next = CONFIRM_MS;
                    if (cnt_reg != MAX_PRESSES) begin
                        cnt_next = cnt_reg + 8'h1;
                    end
                end else if (phase_ms_reg == TIME_PAUSE_MS) begin
                    cfg_next[cfg_ch_reg].mode = timed_hold_mode;
                    cfg_next[cfg_ch_reg].presses = (cnt_reg == 8'h0) ? DEFAULT_PRESSES : cnt_reg;
                    phase_next = ST_NORMAL;
                end
            end
            default: phase_next = ST_NORMAL;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            phase_reg <= ST_NORMAL;
            phase_ms_reg <= 13'h0;
            conf_ms_reg <= 13'h0;
            done_reg <= 1'b0;
            cfg_ch_reg <= 1'b0;
            sel_reg <= follow_frame_mode;
            cnt_reg <= 8'h0;
            cfg_reg[0] <= CFG_RESET;
            cfg_reg[1] <= CFG_RESET;
        end else begin
            phase_reg <= phase_next;
            phase_ms_reg <= phase_ms_next;
            conf_ms_reg <= conf_ms_next;
            done_reg <= done_next;
            cfg_ch_reg <= cfg_ch_next;
            sel_reg <= sel_next;
            cnt_reg <= cnt_next;
            cfg_reg <= cfg_next;
        end
    end

    // Code memory stands for the non-volatile store and is not cleared by reset
    always_ff @(posedge ref_clk) begin
        if (wipe_all) begin
            for (int i = 0; i < DEPTH; i++) begin
                chan_mem[i] <= 2'b00;
            end
        end else if (wr_en) begin
            code_mem[wr_idx] <= rx_code;
            chan_mem[wr_idx] <= wr_bits;
        end
    end

    // ----------------------------------------------------------------
    // Relay channels
    // ----------------------------------------------------------------
    logic [1:0] relay_reg;

    for (genvar c = 0; c < 2; c++) begin : g_chan
        logic [20:0] left_reg, left_next;
        logic on_next;

        always_comb begin
            on_next = relay_reg[c];
            left_next = left_reg;
            if (ms_tick_reg && left_reg != 21'h0) begin
                left_next = left_reg - 21'h1;
            end
            case (cfg_reg[c].mode)
                follow_frame_mode: begin
                    if (chan_hit[c]) begin
                        left_next = 21'(FOLLOW_GAP_MS);
                    end
                    on_next = chan_hit[c] || left_next != 21'h0;
                end
                toggle_output_mode: begin
                    left_next = 21'h0;
                    if (chan_hit[c]) begin
                        on_next = !relay_reg[c];
                    end
                end
                timed_hold_mode: begin
                    if (chan_hit[c]) begin
                        // Both factors widened first so the product keeps all 21 bits
                        left_next = 21'(cfg_reg[c].presses) * 21'(TIME_STEP_MS);
                    end
                    on_next = left_next != 21'h0;
                end
                default: on_next = 1'b0;
            endcase
        end

        always_ff @(posedge ref_clk) begin
            if (srst) begin
                left_reg <= 21'h0;
                relay_reg[c] <= 1'b0;
            end else begin
                left_reg <= left_next;
                relay_reg[c] <= on_next;
            end
        end
    end

    // ----------------------------------------------------------------
    // LED
    // ----------------------------------------------------------------
    led_t led_reg, led_next;
    led_t ch_col;

    always_comb begin
        ch_col = cfg_ch_reg ? led_t'{green: 1'b0, red: 1'b1} : led_t'{green: 1'b1, red: 1'b0};
        case (phase_reg)
            ST_NORMAL: led_next = '{green: relay_reg[0], red: relay_reg[1]};
            ST_LEARN1: led_next = '{green: 1'b1, red: 1'b0};
            ST_LEARN2: led_next = '{green: 1'b0, red: 1'b1};
            ST_ERASE: led_next = '{green: flash, red: flash};
            ST_CFG_SEL: led_next = flash ? ch_col : led_t'{green: 1'b0, red: 1'b0};
            ST_CFG_TIME: led_next = '{green: 1'b1, red: 1'b1};
            default: led_next = '{green: 1'b0, red: 1'b0};
        endcase
        if (conf_ms_reg != 13'h0) begin
            // In time entry the same timer shows each counted press in channel colour
            led_next = (phase_reg == ST_CFG_TIME) ? ch_col : led_t'{green: 1'b0, red: 1'b0};
        end
        if (mem_fault) begin
            led_next = '{green: flash, red: flash};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            led_reg <= '{green: 1'b0, red: 1'b0};
        end else begin
            led_reg <= led_next;
        end
    end

    assign led = led_reg;
    assign relay = relay_reg;
    assign rx_ready = rx_ready_reg;

endmodule

/* tb/user_model.sv */
// Push-button user and remote transmitter model
`timescale 1ns/100ps
module user_model #(
    parameter int CODE_W = 32
) (
    input wire logic ref_clk,
    output logic btn_raw,
    output logic rx_valid,
    output logic [CODE_W-1:0] rx_code
);
    initial begin
        btn_raw = 1'b0;
        rx_valid = 1'b0;
        rx_code = '0;
    end

    task automatic hold(input logic lvl, input int cyc);
        @(posedge ref_clk);
        btn_raw <= lvl;
        repeat (cyc - 1) @(posedge ref_clk);
    endtask

    // Bounce of 30 cycles on both edges, inside the filter at the bench tick, then steady
    task automatic press();
        hold(1'b1, 30);
        hold(1'b0, 30);
        hold(1'b1, 400);
        hold(1'b0, 30);
        hold(1'b1, 30);
        hold(1'b0, 400);
    endtask

    task automatic send(input logic [CODE_W-1:0] code);
        @(posedge ref_clk);
        rx_valid <= 1'b1;
        rx_code <= code;
        @(posedge ref_clk);
        rx_valid <= 1'b0;
        // Code bus carries no stale value once the pulse is gone
        rx_code <= ~code;
    endtask
endmodule

/* tb/relay_ctl_asserts.sv */
// Port-level assertions for the relay controller
`timescale 1ns/100ps
module relay_ctl_asserts #(
    parameter int CLKS_PER_MS = 10,
    parameter int CODE_W = 32,
    parameter int DEPTH = 500
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic btn_raw,
    input wire logic rx_valid,
    input wire logic [CODE_W-1:0] rx_code,
    input wire logic mem_fault,
    input wire relay_ctl_pkg::led_t led,
    input wire logic [1:0] relay,
    input wire logic rx_ready
);
    import relay_ctl_pkg::*;
    localparam int READY_CYC = 2800 * CLKS_PER_MS;
    int up_cnt;
    int hold_cnt;
    led_t led_q;

    // ----------------------------------------------------------------
    // Helper counters
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        led_q <= led;
        if (srst) begin
            up_cnt <= 0;
        end else if (up_cnt < 2 * READY_CYC) begin
            up_cnt <= up_cnt + 1;
        end
        if (srst || !mem_fault || led != led_q) begin
            hold_cnt <= 0;
        end else begin
            hold_cnt <= hold_cnt + 1;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    a_reset_clears:
    assert property (disable iff (1'b0) srst |=> led == 2'b00 && relay == 2'b00 && !rx_ready)
        else $error("outputs not cleared by reset");
    a_ready_early:
    assert property (up_cnt < READY_CYC - CLKS_PER_MS |-> !rx_ready)
        else $error("ready raised too early");
    a_ready_late:
    assert property (up_cnt > READY_CYC + 2 * CLKS_PER_MS |-> rx_ready)
        else $error("ready raised too late");
    a_ready_stays:
    assert property (rx_ready |=> rx_ready)
        else $error("ready dropped without reset");
    a_relay_not_ready:
    assert property (!rx_ready |-> relay == 2'b00)
        else $error("relay active before ready");
    a_relay_frame_cause:
    assert property ((relay & ~$past(relay)) != 2'b00 |-> $past(rx_valid) && $past(rx_ready))
        else $error("relay rose without a frame");
    a_fault_orange:
    assert property (mem_fault && $past(mem_fault) && $past(mem_fault, 2) |-> led.green == led.red)
        else $error("fault light not orange");
    a_fault_flashes:
    assert property (hold_cnt < 260 * CLKS_PER_MS)
        else $error("fault light not flashing");

    c_ready: cover property ($rose(rx_ready));
    c_both_relays: cover property (relay == 2'b11);
    c_fault: cover property (mem_fault && led == 2'b11);
endmodule

bind relay_ctl relay_ctl_asserts #(
    .CLKS_PER_MS(CLKS_PER_MS),
    .CODE_W(CODE_W),
    .DEPTH(DEPTH)
) u_asserts (
    .ref_clk(ref_clk),
    .srst(srst),
    .btn_raw(btn_raw),
    .rx_valid(rx_valid),
    .rx_code(rx_code),
    .mem_fault(mem_fault),
    .led(led),
    .relay(relay),
    .rx_ready(rx_ready)
);

/* tb/relay_ctl_bench.sv */
// Self-checking bench for the relay controller
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
        $display("[ERR] %s exp %h got %h", nm, exp, got); \
        n_fail++; \
    end \
end
module relay_ctl_bench;
    import relay_ctl_pkg::*;
    // Short tick keeps the long phase timeouts inside the cycle budget
    localparam int CPM = 2;
    localparam logic [31:0] CODE_A = 32'h1234abcd;
    localparam logic [31:0] CODE_B = 32'h0f0f5a5a;
    localparam logic [31:0] CODE_C = 32'h7e0081c3;
    logic ref_clk;
    logic srst;
    logic mem_fault;
    logic btn_raw;
    logic rx_valid;
    logic [31:0] rx_code;
    led_t led;
    logic [1:0] relay;
    logic rx_ready;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;
    logic s11;
    logic s00;

    relay_ctl #(.CLKS_PER_MS(CPM), .CODE_W(32), .DEPTH(8)) dut (
        .ref_clk(ref_clk),
        .srst(srst),
        .btn_raw(btn_raw),
        .rx_valid(rx_valid),
        .rx_code(rx_code),
        .mem_fault(mem_fault),
        .led(led),
        .relay(relay),
        .rx_ready(rx_ready)
    );
    user_model #(.CODE_W(32)) u_user (
        .ref_clk(ref_clk),
        .btn_raw(btn_raw),
        .rx_valid(rx_valid),
        .rx_code(rx_code)
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic wait_ms(input int n);
        repeat (n * CPM) @(posedge ref_clk);
        #1;
    endtask

    task automatic settle();
        repeat (3) @(posedge ref_clk);
        #1;
    endtask

    // Notes whether the light was seen orange and seen dark within the span
    task automatic scan(input int ms);
        s11 = 1'b0;
        s00 = 1'b0;
        repeat (ms) begin
            wait_ms(1);
            if (led === 2'b11) s11 = 1'b1;
            if (led === 2'b00) s00 = 1'b1;
        end
    endtask

    task automatic end_sim();
        if (n_fail == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 100000) begin
            n_fail++;
            end_sim();
        end
    end

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_ready();
        #1;
        `CHK("led reset", 2'b00, led)
        `CHK("relay reset", 2'b00, relay)
        u_user.send(CODE_A);
        settle();
        `CHK("relay early frame", 2'b00, relay)
        wait_ms(2780);
        `CHK("ready early", 1'b0, rx_ready)
        wait_ms(30);
        `CHK("ready", 1'b1, rx_ready)
    endtask

    task automatic t_learn1();
        u_user.press();
        `CHK("led learn1", 2'b10, led)
        u_user.send(CODE_A);
        settle();
        `CHK("led confirm", 2'b00, led)
        wait_ms(450);
        `CHK("led confirm late", 2'b00, led)
        wait_ms(100);
        `CHK("led after confirm", 2'b10, led)
        u_user.press();
        `CHK("led exit", 2'b00, led)
        u_user.send(CODE_A);
        settle();
        `CHK("relay follow", 2'b01, relay)
        `CHK("led out1", 2'b10, led)
        wait_ms(100);
        `CHK("relay held", 2'b01, relay)
        wait_ms(100);
        `CHK("relay dropped", 2'b00, relay)
    endtask

    task automatic t_learn2();
        u_user.press();
        u_user.press();
        `CHK("led learn2", 2'b01, led)
        u_user.send(CODE_B);
        wait_ms(510);
        u_user.send(CODE_A);
        wait_ms(510);
        u_user.press();
        `CHK("led exit2", 2'b00, led)
        u_user.send(CODE_A);
        settle();
        `CHK("relay both", 2'b11, relay)
        `CHK("led both", 2'b11, led)
        wait_ms(200);
        u_user.send(CODE_B);
        settle();
        `CHK("relay out2", 2'b10, relay)
        `CHK("led out2", 2'b01, led)
        wait_ms(200);
    endtask

    task automatic t_erase();
        u_user.press();
        u_user.press();
        u_user.press();
        scan(260);
        `CHK("erase lit", 1'b1, s11)
        `CHK("erase dark", 1'b1, s00)
        u_user.send(CODE_C);
        scan(260);
        `CHK("unknown no blank", 1'b1, s11)
        u_user.send(CODE_A);
        scan(300);
        `CHK("erase confirm", 1'b0, s11)
        wait_ms(4400);
        scan(260);
        `CHK("phase restarted", 1'b1, s11)
        wait_ms(900);
        scan(200);
        `CHK("phase expired", 1'b0, s11)
        u_user.send(CODE_A);
        settle();
        `CHK("relay erased", 2'b00, relay)
        u_user.send(CODE_B);
        settle();
        `CHK("relay kept", 2'b10, relay)
        wait_ms(200);
    endtask

    // Store is unknown at start, so the third press is held to wipe it
    task automatic t_wipe();
        u_user.press();
        u_user.press();
        u_user.hold(1'b1, 2800 * CPM);
        scan(150);
        `CHK("erase before wipe", 1'b1, s11)
        wait_ms(100);
        scan(300);
        `CHK("wipe blank", 1'b0, s11)
        u_user.hold(1'b0, 100 * CPM);
    endtask

    task automatic t_toggle();
        u_user.press();
        u_user.hold(1'b1, 3100 * CPM);
        u_user.hold(1'b0, 100 * CPM);
        u_user.press();
        wait_ms(5100);
        `CHK("led cfg done", 2'b00, led)
        u_user.send(CODE_B);
        settle();
        `CHK("relay toggle on", 2'b10, relay)
        wait_ms(300);
        `CHK("relay toggle held", 2'b10, relay)
        u_user.send(CODE_B);
        settle();
        `CHK("relay toggle off", 2'b00, relay)
    endtask

    task automatic t_fault();
        @(posedge ref_clk);
        mem_fault <= 1'b1;
        scan(300);
        `CHK("fault lit", 1'b1, s11)
        `CHK("fault dark", 1'b1, s00)
        @(posedge ref_clk);
        mem_fault <= 1'b0;
    endtask

    initial begin
        srst = 1'b1;
        mem_fault = 1'b0;
        repeat (4) @(posedge ref_clk);
        srst <= 1'b0;
        t_ready();
        t_wipe();
        t_learn1();
        t_learn2();
        t_erase();
        t_toggle();
        t_fault();
        end_sim();
    end
endmodule
